/* File: src/etc_defines.vh */
// constants for the eight-bit timer/counter block
`ifndef ETC_DEFINES_VH
`define ETC_DEFINES_VH
`define ETC_OFF_COUNT 8'h00
`define ETC_OFF_OPTION 8'h04
`define ETC_OFF_INTCTL 8'h08
`define ETC_OFF_STATUS 8'h0c
`define ETC_OFF_MASK 8'h10
`define ETC_OFF_SLEEP 8'h14
`define ETC_OPT_RESET 8'hff
`define ETC_OPT_SRC 5
`define ETC_OPT_EDGE 4
`define ETC_OPT_PSA 3
`define ETC_OPT_PS_HI 2
`define ETC_OPT_PS_LO 0
`define ETC_IC_FLAG 2
`define ETC_IC_EN 5
`define ETC_INHIBIT_CYC 2'h2
`define ETC_RESP_OKAY 2'b00
`define ETC_RESP_SLVERR 2'b10
`endif

/* File: src/etc_prescaler.v */
// shared eight-bit prescaler with selectable tap
`timescale 1ns/1ps
`default_nettype none
module etc_prescaler
(
  // clock and reset
  input wire mclk,
  input wire rst,
  // control
  input wire tick,
  input wire clear,
  input wire [2:0] prescale_select,
  // output
  output reg terminal
);
  reg [7:0] div_q;
  wire [7:0] div_d;
  wire [8:0] sum;
  assign sum = {1'b0, div_q} + 9'h001;
  assign div_d = sum[7:0];
  always @*
  begin
    terminal = tick & (div_q[prescale_select] == 1'b1) & (sum[prescale_select]
      == 1'b0);
  end
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
      div_q <= 8'h00;
    else if (clear)
      div_q <= 8'h00;
    else if (tick)
      div_q <= div_d;
  end
endmodule
`default_nettype wire

/* File: src/etc_timer.v */
// eight-bit timer/counter with axi4-lite registers
//
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "etc_defines.vh"
module etc_timer
(
  // clock and reset
  input wire mclk,
  input wire rst,
  // axi4-lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // external count pin and watchdog
  input wire external_count_input,
  input wire wdt_tick,
  output reg wdt_timeout,
  // interrupts
  output reg overflow_irq,
  output reg irq
);
  reg [7:0] count_value_register;
  reg [7:0] option_q;
  reg [7:0] intctl_q;
  reg status_q;
  reg mask_q;
  reg sleep_q;
  reg [1:0] inhibit_q;
  reg pin_s1_q;
  reg pin_s2_q;
  reg pin_s3_q;
  reg [7:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg aw_have_q;
  reg w_have_q;
  wire count_source_select;
  wire count_edge_select;
  wire prescaler_assignment;
  wire [2:0] prescale_select;
  wire overflow_flag;
  wire overflow_irq_enable;
  wire rise;
  wire fall;
  wire src_tick;
  wire pre_tick;
  wire pre_term;
  wire cnt_step;
  wire wrap;
  wire do_write;
  wire wr_count;
  wire wr_option;
  wire wr_intctl;
  wire rd_take;
  wire rd_status;
  wire wdt_term;
  reg [31:0] rd_val;
  reg rd_ok;
  assign count_source_select = option_q[`ETC_OPT_SRC];
  assign count_edge_select = option_q[`ETC_OPT_EDGE];
  assign prescaler_assignment = option_q[`ETC_OPT_PSA];
  assign prescale_select = option_q[`ETC_OPT_PS_HI:`ETC_OPT_PS_LO];
  assign overflow_flag = intctl_q[`ETC_IC_FLAG];
  assign overflow_irq_enable = intctl_q[`ETC_IC_EN];
  // pin passes three flops; edge logic looks only at the later stages
  assign rise = pin_s2_q & ~pin_s3_q;
  assign fall = ~pin_s2_q & pin_s3_q;
  assign src_tick = count_source_select ?
    (count_edge_select ? fall : rise) : 1'b1;
  // prescaler is fed from the counter source or the watchdog, never both
  assign pre_tick = prescaler_assignment ? wdt_tick : src_tick;
  // sleep and inhibit hold the counter only; the prescaler keeps running
  assign cnt_step = ~sleep_q & (inhibit_q == 2'b00) &
    (prescaler_assignment ? src_tick : pre_term);
  assign wdt_term = prescaler_assignment ? pre_term : wdt_tick;
  // a write overrides the step of its own edge, so it raises no overflow
  assign wrap = cnt_step & ~wr_count &
    (count_value_register == 8'hff);
  assign do_write = aw_have_q & w_have_q & ~s_axi_bvalid;
  assign wr_count = do_write & (awaddr_q == `ETC_OFF_COUNT) & wstrb_q[0];
  assign wr_option = do_write & (awaddr_q == `ETC_OFF_OPTION) & wstrb_q[0];
  assign wr_intctl = do_write & (awaddr_q == `ETC_OFF_INTCTL) & wstrb_q[0];
  assign rd_take = s_axi_arvalid & s_axi_arready;
  assign rd_status = rd_take & (s_axi_araddr == `ETC_OFF_STATUS);
  etc_prescaler u_pre
  (
    .mclk(mclk),
    .rst(rst),
    .tick(pre_tick),
    .clear(wr_count | wr_option),
    .prescale_select(prescale_select),
    .terminal(pre_term)
  );
  function is_mapped;
    input [7:0] a;
    begin
      is_mapped = (a == `ETC_OFF_COUNT) | (a == `ETC_OFF_OPTION) |
        (a == `ETC_OFF_INTCTL) | (a == `ETC_OFF_STATUS) |
        (a == `ETC_OFF_MASK) | (a == `ETC_OFF_SLEEP);
    end
  endfunction
  // unmapped reads return zero with an error response
  always @*
  begin
    rd_val = 32'h00000000;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `ETC_OFF_COUNT: rd_val[7:0] = count_value_register;
      `ETC_OFF_OPTION: rd_val[7:0] = option_q;
      `ETC_OFF_INTCTL: rd_val[7:0] = intctl_q;
      `ETC_OFF_STATUS: rd_val[0] = status_q;
      `ETC_OFF_MASK: rd_val[0] = mask_q;
      `ETC_OFF_SLEEP: rd_val[0] = sleep_q;
      default: rd_ok = 1'b0;
    endcase
  end
  // pin synchroniser
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_s3_q <= 1'b0;
    end
    else
    begin
      pin_s1_q <= external_count_input;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end
  // counter and inhibit window
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      count_value_register <= 8'h00;
      inhibit_q <= 2'b00;
    end
    else if (wr_count)
    begin
      count_value_register <= wdata_q[7:0];
      inhibit_q <= `ETC_INHIBIT_CYC;
    end
    else
    begin
      if (inhibit_q != 2'b00)
        inhibit_q <= inhibit_q - 2'b01;
      if (cnt_step)
        count_value_register <= count_value_register + 8'h01;
    end
  end
  // control registers and flags; a hardware set wins over a clear
  // option resets to all ones: prescaler on the watchdog, slowest ratio
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      option_q <= `ETC_OPT_RESET;
      intctl_q <= 8'h00;
      status_q <= 1'b0;
      mask_q <= 1'b0;
      sleep_q <= 1'b0;
    end
    else
    begin
      if (wr_option)
        option_q <= wdata_q[7:0];
      if (wr_intctl)
        intctl_q <= wdata_q[7:0];
      if (wrap)
        intctl_q[`ETC_IC_FLAG] <= 1'b1;
      if (do_write & (awaddr_q == `ETC_OFF_MASK) & wstrb_q[0])
        mask_q <= wdata_q[0];
      if (do_write & (awaddr_q == `ETC_OFF_SLEEP) & wstrb_q[0])
        sleep_q <= wdata_q[0];
      if (wrap)
        status_q <= 1'b1;
      else if (rd_status)
        status_q <= 1'b0;
    end
  end
  // outputs from flops
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      overflow_irq <= 1'b0;
      irq <= 1'b0;
      wdt_timeout <= 1'b0;
    end
    else
    begin
      overflow_irq <= overflow_flag & overflow_irq_enable;
      irq <= status_q & mask_q;
      wdt_timeout <= wdt_term;
    end
  end
  // axi4-lite write path: address and data taken in either order
  // idle readies toggle, so an offer waits at most one extra cycle
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ETC_RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= ~aw_have_q & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready <= ~w_have_q & ~s_axi_wready & ~s_axi_bvalid;
      if (s_axi_awvalid & s_axi_awready)
      begin
        awaddr_q <= s_axi_awaddr;
        aw_have_q <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        w_have_q <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_mapped(awaddr_q) ? `ETC_RESP_OKAY :
          `ETC_RESP_SLVERR;
      end
      else if (s_axi_bvalid & s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
      end
    end
  end
  // axi4-lite read path
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `ETC_RESP_OKAY;
    end
    else
    begin
      if (rd_take)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_ok ? `ETC_RESP_OKAY : `ETC_RESP_SLVERR;
      end
      else
      begin
        // ready rises whether or not arvalid already waits, so a master
        // that offers the address first is never left hanging
        if (~s_axi_arready & ~s_axi_rvalid)
          s_axi_arready <= 1'b1;
        if (s_axi_rvalid & s_axi_rready)
          s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: testbench/etc_edge_src.sv */
// external count source: a burst of seven pin toggles, then the pin stands
`timescale 1ns/1ps
`default_nettype none
module etc_edge_src
(
  // clock and request
  input wire logic mclk,
  input wire logic start,
  // count pin
  output logic pin
);
  int left = 0;
  initial pin = 1'b0;
  // odd toggle count so rising and falling edge totals differ
  always @(posedge mclk)
  begin
    if (start)
      left <= 7;
    else if (left > 0)
    begin
      pin <= !pin;
      left <= left - 1;
    end
  end
endmodule
`default_nettype wire

/* File: testbench/etc_timer_sva.sv */
// checker for the timer's bus handshakes and interrupt outputs
`timescale 1ns/1ps
`default_nettype none
module etc_timer_sva
(
  // clock, reset, bus handshakes and interrupts
  input wire logic mclk, rst, s_axi_awvalid, s_axi_awready,
  input wire logic s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready,
  input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic [31:0] s_axi_rdata,
  input wire logic overflow_irq, irq
);
  // a flag may only fall shortly after software touched the registers
  wire wt = s_axi_wvalid && s_axi_wready;
  wire acc = wt || (s_axi_arvalid && s_axi_arready);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
  a_rd_late: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("late rvalid");
  a_wr_late: assert property (s_axi_awvalid && s_axi_awready && wt
    |-> ##[1:2] s_axi_bvalid) else $error("late bvalid");
  a_b_code: assert property (s_axi_bvalid
    |-> s_axi_bresp inside {2'b00, 2'b10}) else $error("bad bresp");
  a_r_upper: assert property (s_axi_rvalid
    |-> s_axi_rdata[31:8] == 24'h0) else $error("upper bits set");
  a_ovf_stay: assert property ($fell(overflow_irq)
    |-> $past(wt) || $past(wt, 2) || $past(wt, 3)) else $error("flag lost");
  a_irq_stay: assert property ($fell(irq)
    |-> $past(acc) || $past(acc, 2) || $past(acc, 3)) else $error("irq lost");
endmodule
bind etc_timer etc_timer_sva i_sva (.*);
`default_nettype wire

/* File: testbench/etc_timer_tb.sv */
// self-checking bench for the eight-bit timer/counter
`timescale 1ns/1ps
`default_nettype none
`include "etc_defines.vh"
module etc_timer_tb;
  logic mclk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, go, lv;
  logic s_axi_arvalid, s_axi_rready, external_count_input, wdt_tick;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, rd, seed;
  logic [3:0] s_axi_wstrb;
  logic [1:0] resp;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire wdt_timeout, overflow_irq, irq;
  int n_errors = 0, n_compared = 0, cyc = 0, tw, tr, v, w;
  etc_timer i_etc_timer (.*);
  etc_edge_src i_etc_edge_src (.mclk(mclk), .start(go),
    .pin(external_count_input));
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = !mclk;
  end
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_errors = n_errors + 1;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp)
    begin
      n_errors = n_errors + 1;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // tw and tr hold the cycle of the edge that took the data or address
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do
    begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        s_axi_wvalid <= 1'b0;
        tw = cyc;
      end
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge mclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do
    begin
      @(posedge mclk);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arvalid <= 1'b0;
        tr = cyc;
      end
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  initial
  begin
    seed = 32'd52892;
    rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
    {s_axi_rready, wdt_tick, go} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'hf;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rd_reg(`ETC_OFF_OPTION);
    chk(rd, `ETC_OPT_RESET);
    rd_reg(8'h40);
    chk(resp, `ETC_RESP_SLVERR);
    wr(8'h40, 32'h0);
    chk(resp, `ETC_RESP_SLVERR);
    wr(`ETC_OFF_OPTION, 32'h08);
    chk(resp, `ETC_RESP_OKAY);
    repeat (3)
    begin
      w = rnd() & 255;
      wr(`ETC_OFF_COUNT, w);
      rd_reg(`ETC_OFF_COUNT);
      chk(rd, (w + tr - tw - 4) & 255);
      {v, w} = {tr, rd};
      rd_reg(`ETC_OFF_COUNT);
      chk(rd, (w + tr - v) & 255);
    end
    wr(`ETC_OFF_INTCTL, 32'h20);
    wr(`ETC_OFF_COUNT, 32'hfe);
    repeat (8) @(negedge mclk);
    chk({overflow_irq, irq}, 2'h2);
    rd_reg(`ETC_OFF_INTCTL);
    chk(rd, 32'h24);
    rd_reg(`ETC_OFF_STATUS);
    rd_reg(`ETC_OFF_STATUS);
    chk(rd, 32'h0);
    wr(`ETC_OFF_INTCTL, 32'h04);
    repeat (2) @(negedge mclk);
    chk(overflow_irq, 1'b0);
    wr(`ETC_OFF_INTCTL, 32'h0);
    wr(`ETC_OFF_MASK, 32'h1);
    for (v = 0; v < 300 && irq !== 1'b1; v++)
      @(negedge mclk);
    chk(irq, 1'b1);
    rd_reg(`ETC_OFF_STATUS);
    repeat (2) @(negedge mclk);
    chk(irq, 1'b0);
    rd_reg(`ETC_OFF_INTCTL);
    chk(rd, 32'h04);
    wr(`ETC_OFF_SLEEP, 32'h1);
    rd_reg(`ETC_OFF_STATUS);
    rd_reg(`ETC_OFF_COUNT);
    w = rd;
    repeat (300) @(posedge mclk);
    rd_reg(`ETC_OFF_COUNT);
    chk(rd, w);
    rd_reg(`ETC_OFF_STATUS);
    chk(rd, 32'h0);
    wr(`ETC_OFF_SLEEP, 32'h0);
    // the prescaler phase at the first read is free, so allow one step
    for (int ps = 0; ps < 3; ps++)
    begin
      wr(`ETC_OFF_OPTION, ps);
      rd_reg(`ETC_OFF_COUNT);
      {v, w} = {tr, rd};
      repeat (40) @(posedge mclk);
      rd_reg(`ETC_OFF_COUNT);
      w = ((rd - w) & 255) << (ps + 1);
      chk(w >= tr - v - (2 << ps) && w <= tr - v + (2 << ps), 1'b1);
    end
    for (int j = 0; j < 3; j++)
    begin
      if (j == 1)
        wr(`ETC_OFF_OPTION, 32'h08);
      @(posedge mclk);
      wdt_tick <= 1'b1;
      @(posedge mclk);
      wdt_tick <= 1'b0;
      @(negedge mclk);
      lv = wdt_timeout;
      @(negedge mclk);
      chk(lv | wdt_timeout, j != 1);
    end
    for (int e = 1; e >= 0; e--)
    begin
      wr(`ETC_OFF_OPTION, 32'h28 | (e << 4));
      wr(`ETC_OFF_COUNT, 32'h0);
      @(posedge mclk);
      go <= 1'b1;
      @(posedge mclk);
      go <= 1'b0;
      repeat (20) @(posedge mclk);
      rd_reg(`ETC_OFF_COUNT);
      chk(rd, 32'h3);
    end
    end_of_test();
  end
endmodule
`default_nettype wire
